// File: logic/xag_defs.svh
`ifndef XAG_DEFS_SVH
`define XAG_DEFS_SVH
`define XAG_RAM_BYTES      768
`define XAG_RAM_LAST       16'h02FF
`define XAG_ADDR_PTR_LOW   8'h82
`define XAG_ADDR_PTR_HIGH  8'h83
`define XAG_ADDR_PAGE      8'h8F
`define XAG_ADDR_AUX1      8'hA2
`define XAG_PAGE_BITS      2
`define XAG_SEL_BIT        0
`define XAG_PTR_RESET      16'h0000
`define XAG_CODE_BYTES     16384
`endif

// File: logic/xag_expanded_ram_address_generation.sv
// Function
// - 768-byte expanded ram at 0x0000-0x02FF, reached only by external data moves.
// - no off-chip data path; moves above 0x02FF write nothing and read as zero.
// - register-indirect move: page register is high byte, working register low byte.
// - pointer-form move uses full 16-bit selected pointer for reads and writes.
// - two independent 16-bit pointers, chosen by auxiliary control bit 0.
// - select 0 picks pointer zero, 1 picks pointer one; select resets to 0.
// - six ops use selected pointer: inc, load, code read, ram read/write, jump.
// - selected pointer bytes at 0x82 low and 0x83 high, read/write, reset zero.
// - two-bit page field picks a 256-byte page; page 3 lies above the 768-byte ram.
// - page register reserved bits always read as zero.
// - paged region and pointer region share one physical storage.
// - code read fetches 16K program memory at accumulator plus selected pointer.
`timescale 1ns/100ps
`default_nettype none
`include "xag_defs.svh"
module xag_expanded_ram_address_generation #(
  parameter int RAM_BYTES  = `XAG_RAM_BYTES,
  parameter int CODE_BYTES = `XAG_CODE_BYTES
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire xag_pkg::xag_sfr_req_t sfrReq,
  output var  logic [7:0]            sfrRdata,
  input  wire xag_pkg::xag_ptr_cmd_t ptrCmd,
  input  wire xag_pkg::xag_reg_move_t regMove,
  output var  logic [7:0]            ramRdata,
  output logic [15:0]                codeAddr,
  output logic                       codeRd,
  output logic [15:0]                jumpTarget,
  output logic                       jumpValid
);
  import xag_pkg::*;

  // ==========================================================
  // state
  logic [15:0] pointerZero_reg;
  logic [15:0] pointerOne_reg;
  logic        pointerSelect_reg;
  logic [1:0]  ramPage_reg;
  logic [7:0]  expandedRam [RAM_BYTES];
  logic [15:0] selPtr;
  logic [15:0] selPtrNext;
  logic [15:0] ramAddr;
  logic        ramRd;
  logic        ramWr;
  logic [7:0]  ramWdata;
  logic        inRange;

  function automatic logic addrInRange(input logic [15:0] a);
    addrInRange = (a <= `XAG_RAM_LAST);
  endfunction : addrInRange

  assign selPtr = pointerSelect_reg ? pointerOne_reg : pointerZero_reg;

  // ==========================================================
  // pointer update
  always_comb begin
    selPtrNext = selPtr;
    case (ptrCmd.op)
      XAG_OP_INC:  selPtrNext = selPtr + 16'h0001;
      XAG_OP_LOAD: selPtrNext = ptrCmd.imm;
      default:     selPtrNext = selPtr;
    endcase
    if (sfrReq.wr && sfrReq.addr == `XAG_ADDR_PTR_LOW) begin
      selPtrNext = {selPtr[15:8], sfrReq.wdata};
    end
    if (sfrReq.wr && sfrReq.addr == `XAG_ADDR_PTR_HIGH) begin
      selPtrNext = {sfrReq.wdata, selPtr[7:0]};
    end
  end

  // only the selected pointer moves; the other keeps its value
  always_ff @(posedge clock) begin
    if (rst) begin
      pointerZero_reg <= `XAG_PTR_RESET;
      pointerOne_reg  <= `XAG_PTR_RESET;
    end else if (pointerSelect_reg) begin
      pointerOne_reg <= selPtrNext;
    end else begin
      pointerZero_reg <= selPtrNext;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pointerSelect_reg <= 1'b0;
    end else if (sfrReq.wr && sfrReq.addr == `XAG_ADDR_AUX1) begin
      pointerSelect_reg <= sfrReq.wdata[`XAG_SEL_BIT];
    end
  end

  // upper bits are not stored, so they can never reach the address
  always_ff @(posedge clock) begin
    if (rst) begin
      ramPage_reg <= 2'h0;
    end else if (sfrReq.wr && sfrReq.addr == `XAG_ADDR_PAGE) begin
      ramPage_reg <= sfrReq.wdata[`XAG_PAGE_BITS-1:0];
    end
  end

  // ==========================================================
  // register reads
  always_ff @(posedge clock) begin
    if (rst) begin
      sfrRdata <= 8'h00;
    end else if (sfrReq.rd) begin
      case (sfrReq.addr)
        `XAG_ADDR_PTR_LOW:  sfrRdata <= selPtr[7:0];
        `XAG_ADDR_PTR_HIGH: sfrRdata <= selPtr[15:8];
        `XAG_ADDR_PAGE:     sfrRdata <= {6'h00, ramPage_reg};
        `XAG_ADDR_AUX1:     sfrRdata <= {7'h00, pointerSelect_reg};
        default:            sfrRdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // expanded ram access
  // register moves take priority if the core ever issues both in one cycle
  always_comb begin
    if (regMove.rd || regMove.wr) begin
      ramAddr  = {6'h00, ramPage_reg, regMove.low};
      ramRd    = regMove.rd;
      ramWr    = regMove.wr;
      ramWdata = regMove.wdata;
    end else begin
      ramAddr  = selPtr;
      ramRd    = (ptrCmd.op == XAG_OP_RAM_READ);
      ramWr    = (ptrCmd.op == XAG_OP_RAM_WRITE);
      ramWdata = ptrCmd.wdata;
    end
  end

  assign inRange = addrInRange(ramAddr);

  // one array serves both forms; no external strobe exists
  always_ff @(posedge clock) begin
    if (ramWr && inRange) begin
      expandedRam[ramAddr[9:0]] <= ramWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ramRdata <= 8'h00;
    end else if (ramRd) begin
      ramRdata <= inRange ? expandedRam[ramAddr[9:0]] : 8'h00;
    end
  end

  // ==========================================================
  // code fetch and jump
  always_ff @(posedge clock) begin
    if (rst) begin
      codeAddr   <= 16'h0000;
      codeRd     <= 1'b0;
      jumpTarget <= 16'h0000;
      jumpValid  <= 1'b0;
    end else begin
      codeRd    <= (ptrCmd.op == XAG_OP_CODE_READ);
      jumpValid <= (ptrCmd.op == XAG_OP_JUMP);
      if (ptrCmd.op == XAG_OP_CODE_READ) begin
        // wraps inside the program space
        codeAddr <= (selPtr + {8'h00, ptrCmd.acc}) & 16'(CODE_BYTES - 1);
      end
      if (ptrCmd.op == XAG_OP_JUMP) begin
        jumpTarget <= selPtr + {8'h00, ptrCmd.acc};
      end
    end
  end

  // ==========================================================
  // checks
  property p_sel_reset;
    @(posedge clock) rst |=> (pointerSelect_reg == 1'b0);
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select not zero after reset");

  property p_inc;
    @(posedge clock) disable iff (rst)
      (ptrCmd.op == XAG_OP_INC && !sfrReq.wr && !sfrReq.rd)
      |=> (selPtr == $past(selPtr) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc) else $error("pointer increment wrong");

  property p_load;
    @(posedge clock) disable iff (rst)
      (ptrCmd.op == XAG_OP_LOAD && !sfrReq.wr) |=> (selPtr == $past(ptrCmd.imm));
  endproperty
  a_load: assert property (p_load) else $error("pointer load wrong");

  property p_other_hold;
    @(posedge clock) disable iff (rst)
      (!pointerSelect_reg) |=> (pointerOne_reg == $past(pointerOne_reg));
  endproperty
  a_other_hold: assert property (p_other_hold) else $error("unselected pointer moved");

  property p_page_read;
    @(posedge clock) disable iff (rst)
      (sfrReq.rd && sfrReq.addr == `XAG_ADDR_PAGE) |=> (sfrRdata[7:2] == 6'h00);
  endproperty
  a_page_read: assert property (p_page_read) else $error("page reserved bits nonzero");

  property p_high_read;
    @(posedge clock) disable iff (rst)
      (sfrReq.rd && sfrReq.addr == `XAG_ADDR_PTR_HIGH) |=> (sfrRdata == $past(selPtr[15:8]));
  endproperty
  a_high_read: assert property (p_high_read) else $error("pointer high read wrong");

  property p_oor_read;
    @(posedge clock) disable iff (rst)
      (ramRd && !inRange) |=> (ramRdata == 8'h00);
  endproperty
  a_oor_read: assert property (p_oor_read) else $error("out of range read nonzero");

  property p_paged_addr;
    @(posedge clock) disable iff (rst)
      (regMove.rd || regMove.wr) |-> (ramAddr[9:8] == ramPage_reg && ramAddr[7:0] == regMove.low);
  endproperty
  a_paged_addr: assert property (p_paged_addr) else $error("paged address wrong");

  property p_ptr_addr;
    @(posedge clock) disable iff (rst)
      (!regMove.rd && !regMove.wr && ptrCmd.op == XAG_OP_RAM_WRITE) |-> (ramAddr == selPtr);
  endproperty
  a_ptr_addr: assert property (p_ptr_addr) else $error("pointer address wrong");

  property p_code;
    @(posedge clock) disable iff (rst)
      (ptrCmd.op == XAG_OP_CODE_READ) |=> codeRd
        && codeAddr == (($past(selPtr) + {8'h00, $past(ptrCmd.acc)}) & 16'h3FFF);
  endproperty
  a_code: assert property (p_code) else $error("code address wrong");
endmodule : xag_expanded_ram_address_generation
`default_nettype wire

// File: logic/xag_pkg.sv
`default_nettype none
package xag_pkg;
  typedef enum logic [2:0] {
    XAG_OP_NONE,
    XAG_OP_INC,
    XAG_OP_LOAD,
    XAG_OP_CODE_READ,
    XAG_OP_RAM_READ,
    XAG_OP_RAM_WRITE,
    XAG_OP_JUMP
  } xag_ptr_op_t;

  typedef struct packed {
    xag_ptr_op_t op;
    logic [15:0] imm;
    logic [7:0]  acc;
    logic [7:0]  wdata;
  } xag_ptr_cmd_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xag_sfr_req_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] low;
    logic [7:0] wdata;
  } xag_reg_move_t;
endpackage : xag_pkg
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import xag_pkg::*;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  xag_sfr_req_t  sfrReq = '0;
  xag_ptr_cmd_t  ptrCmd = '0;
  xag_reg_move_t regMove = '0;
  logic [7:0]    sfrRdata, ramRdata, fetchCount;
  logic [15:0]   codeAddr, jumpTarget, pcReg;
  logic          codeRd, jumpValid;
  int            badCount = 0, testsRun = 0, cycles = 0;
  xag_expanded_ram_address_generation DUT (.clock(clock), .rst(rst), .sfrReq(sfrReq),
    .sfrRdata(sfrRdata), .ptrCmd(ptrCmd), .regMove(regMove), .ramRdata(ramRdata),
    .codeAddr(codeAddr), .codeRd(codeRd), .jumpTarget(jumpTarget), .jumpValid(jumpValid));
  xag_core_model core (.clock(clock), .rst(rst), .jumpTarget(jumpTarget),
    .jumpValid(jumpValid), .codeRd(codeRd), .pcReg(pcReg), .fetchCount(fetchCount));
  initial forever #2 clock = ~clock;
  // ==========
  // tasks: one cycle per request, inputs move 1 ns after the edge
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input xag_sfr_req_t s, input xag_ptr_cmd_t p, input xag_reg_move_t m);
    sfrReq = s;
    ptrCmd = p;
    regMove = m;
    @(posedge clock);
    #1;
    // inputs hold until the next call, so nothing is assigned twice in one step
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc('{1'b0, 1'b1, a, d}, '0, '0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cyc('{1'b1, 1'b0, a, 8'h00}, '0, '0);
    chk({8'h00, sfrRdata}, {8'h00, exp});
  endtask : rd
  task automatic op(input xag_ptr_op_t o, input logic [15:0] i, input logic [7:0] a,
                    input logic [7:0] d);
    cyc('0, '{o, i, a, d}, '0);
  endtask : op
  task automatic mv(input logic r, input logic [7:0] lo, input logic [7:0] d);
    cyc('0, '0, '{r, ~r, lo, d});
  endtask : mv
  // ==========
  // timeout: whole sequence needs well under 200 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      report_and_stop();
    end
  end
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h00);
    rd(8'hA2, 8'h00);
    wr(8'hA2, 8'h01);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    rd(8'h82, 8'h34);
    rd(8'hA2, 8'h01);
    wr(8'hA2, 8'h00);
    rd(8'h83, 8'h00);
    op(XAG_OP_LOAD, 16'h0105, 8'h00, 8'h00);
    op(XAG_OP_RAM_WRITE, 16'h0, 8'h00, 8'hAA);
    wr(8'h8F, 8'h01);
    mv(1'b1, 8'h05, 8'h00);
    chk({8'h00, ramRdata}, 16'h00AA);
    mv(1'b0, 8'h06, 8'h55);
    op(XAG_OP_INC, 16'h0, 8'h00, 8'h00);
    op(XAG_OP_RAM_READ, 16'h0, 8'h00, 8'h00);
    chk({8'h00, ramRdata}, 16'h0055);
    rd(8'h82, 8'h06);
    op(XAG_OP_CODE_READ, 16'h0, 8'h10, 8'h00);
    chk({15'h0, codeRd}, 16'h0001);
    chk(codeAddr, 16'h0116);
    op(XAG_OP_JUMP, 16'h0, 8'h02, 8'h00);
    chk(jumpTarget, 16'h0108);
    chk({15'h0, jumpValid}, 16'h0001);
    op(XAG_OP_NONE, 16'h0, 8'h00, 8'h00);
    chk({15'h0, jumpValid}, 16'h0000);
    chk(pcReg, 16'h0108);
    chk({8'h00, fetchCount}, 16'h0001);
    wr(8'h8F, 8'h03);
    rd(8'h8F, 8'h03);
    mv(1'b0, 8'h05, 8'h77);
    mv(1'b1, 8'h05, 8'h00);
    chk({8'h00, ramRdata}, 16'h0000);
    wr(8'h8F, 8'h01);
    mv(1'b1, 8'h05, 8'h00);
    chk({8'h00, ramRdata}, 16'h00AA);
    op(XAG_OP_LOAD, 16'h02FF, 8'h00, 8'h00);
    op(XAG_OP_RAM_WRITE, 16'h0, 8'h00, 8'h5A);
    op(XAG_OP_RAM_READ, 16'h0, 8'h00, 8'h00);
    chk({8'h00, ramRdata}, 16'h005A);
    op(XAG_OP_INC, 16'h0, 8'h00, 8'h00);
    op(XAG_OP_RAM_READ, 16'h0, 8'h00, 8'h00);
    chk({8'h00, ramRdata}, 16'h0000);
    rd(8'h90, 8'h00);
    // mid-run reset: select, page and the high byte of pointer zero must return to zero
    wr(8'hA2, 8'h01);
    rst = 1'b1;
    cyc('0, '0, '0);
    rst = 1'b0;
    rd(8'hA2, 8'h00);
    rd(8'h83, 8'h00);
    rd(8'h8F, 8'h00);
    cyc('0, '0, '0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire

// File: testbench/xag_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// core model: follows jumps, counts code fetches
module xag_core_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] jumpTarget,
  input  wire logic        jumpValid,
  input  wire logic        codeRd,
  output logic      [15:0] pcReg,
  output logic      [7:0]  fetchCount
);
  always_ff @(posedge clock) begin
    if (rst) pcReg <= 16'h0000;
    else if (jumpValid) pcReg <= jumpTarget;
  end
  always_ff @(posedge clock) begin
    if (rst) fetchCount <= 8'h00;
    else if (codeRd) fetchCount <= fetchCount + 8'h01;
  end
endmodule : xag_core_model
`default_nettype wire
